// >>> dv/mie_exec_tb.sv
// Self-checking bench for the second-half instruction executor.
// Assumes mie_pkg and mie_regs.svh compiled first; APB is the only path in.
`timescale 1ns/1ps
`include "mie_regs.svh"
module mie_exec_tb
   import mie_pkg::*;
;
   logic pclk, presetn, clk_en, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, file_we, watchdog_clear, osc_stop;
   logic global_irq_enable;
   logic [6:0] file_addr, waddr;
   logic [7:0] file_rdata, file_wdata, wlast;
   logic [12:0] program_counter, stack_top;
   int n_fail, n_tests, wcnt, wdcnt, cyc;

   mie_exec i_mie_exec (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .file_addr(file_addr), .file_rdata(file_rdata),
      .file_wdata(file_wdata), .file_we(file_we),
      .program_counter(program_counter), .stack_top(stack_top),
      .watchdog_clear(watchdog_clear), .osc_stop(osc_stop),
      .global_irq_enable(global_irq_enable));

   // ==========================================
   // Clock, monitors, hang guard
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Strobes read mid-cycle, away from the edge that moves them
   always @(negedge pclk) begin
      if (file_we === 1'b1) begin
         wcnt <= wcnt + 1;
         wlast <= file_wdata;
         waddr <= file_addr;
      end
      if (watchdog_clear === 1'b1) wdcnt <= wdcnt + 1;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                         input string m);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q, e, m);
   endtask

   task automatic run(input logic [13:0] ins);
      logic [31:0] q;
      int n;
      wr(`MIE_OFF_INSTR, {18'h0, ins});
      n = 0;
      do begin
         xfer(1'b0, `MIE_OFF_CTRL, 32'h0, q);
         n++;
      end while (q[0] !== 1'b0 && n < 20);
      chk({31'h0, q[0]}, 32'h0, "busy");
   endtask

   // One opcode, then accumulator, status and file write compared
   task automatic op(input logic [13:0] ins, input logic [7:0] frd,
      input logic [7:0] acc_e, st_e, input logic we_e,
      input logic [7:0] wd_e);
      int w0;
      w0 = wcnt;
      file_rdata <= frd;
      run(ins);
      rd_chk(`MIE_OFF_ACC, {24'h0, acc_e}, "acc");
      rd_chk(`MIE_OFF_STATUS, {24'h0, st_e}, "status");
      chk(32'(wcnt - w0), {31'h0, we_e}, "file writes");
      if (we_e) begin
         chk({24'h0, wlast}, {24'h0, wd_e}, "file data");
         chk({25'h0, waddr}, {25'h0, ins[6:0]}, "file addr");
      end
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset();
      rd_chk(`MIE_OFF_STATUS, 32'h18, "status rst");
      rd_chk(`MIE_OFF_ACC, 32'h0, "acc rst");
      rd_chk(`MIE_OFF_OPTION, 32'hff, "option rst");
      rd_chk(`MIE_OFF_DIR6, 32'hff, "dir rst");
      rd_chk(`MIE_OFF_PC, 32'h0, "pc rst");
      rd_chk(12'h100, 32'h0, "unmapped");
      chk({31'h0, pslverr}, 32'h0, "no error");
      chk({31'h0, pready}, 32'h1, "ready");
      $display("test reset done");
   endtask

   task automatic t_logic();
      op(14'h335a, 8'h00, 8'h5a, 8'h18, 1'b0, 8'h00);
      op(14'h3a5a, 8'h00, 8'h00, 8'h1c, 1'b0, 8'h00);
      op(14'h3091, 8'h00, 8'h91, 8'h1c, 1'b0, 8'h00);
      op(14'h0420, 8'h13, 8'h93, 8'h18, 1'b0, 8'h00);
      op(14'h04a0, 8'h00, 8'h93, 8'h18, 1'b1, 8'h93);
      op(14'h30b5, 8'h00, 8'hb5, 8'h18, 1'b0, 8'h00);
      op(14'h06a1, 8'haf, 8'hb5, 8'h18, 1'b1, 8'h1a);
      op(14'h0621, 8'hb5, 8'h00, 8'h1c, 1'b0, 8'h00);
      op(14'h3aaf, 8'h00, 8'haf, 8'h18, 1'b0, 8'h00);
      op(14'h08c5, 8'h00, 8'haf, 8'h1c, 1'b1, 8'h00);
      op(14'h00c5, 8'h00, 8'haf, 8'h1c, 1'b1, 8'haf);
      op(14'h0845, 8'h7e, 8'h7e, 8'h18, 1'b0, 8'h00);
      $display("test logic done");
   endtask

   task automatic t_arith();
      op(14'h3002, 8'h00, 8'h02, 8'h18, 1'b0, 8'h00);
      op(14'h0290, 8'h03, 8'h02, 8'h1b, 1'b1, 8'h01);
      op(14'h0210, 8'h02, 8'h00, 8'h1f, 1'b0, 8'h00);
      op(14'h3002, 8'h00, 8'h02, 8'h1f, 1'b0, 8'h00);
      op(14'h0290, 8'h01, 8'h02, 8'h18, 1'b1, 8'hff);
      op(14'h3001, 8'h00, 8'h01, 8'h18, 1'b0, 8'h00);
      op(14'h3c20, 8'h00, 8'h1f, 8'h19, 1'b0, 8'h00);
      op(14'h3003, 8'h00, 8'h03, 8'h19, 1'b0, 8'h00);
      op(14'h3d02, 8'h00, 8'hff, 8'h18, 1'b0, 8'h00);
      $display("test subtract done");
   endtask

   task automatic t_rotate();
      op(14'h0d10, 8'he6, 8'hcc, 8'h19, 1'b0, 8'h00);
      op(14'h0d90, 8'h01, 8'hcc, 8'h18, 1'b1, 8'h03);
      op(14'h0c10, 8'h01, 8'h00, 8'h19, 1'b0, 8'h00);
      op(14'h0e10, 8'ha5, 8'h5a, 8'h19, 1'b0, 8'h00);
      op(14'h0e90, 8'h3c, 8'h5a, 8'h19, 1'b1, 8'hc3);
      op(14'h0c90, 8'h02, 8'h5a, 8'h18, 1'b1, 8'h81);
      $display("test rotate done");
   endtask

   task automatic t_legacy();
      logic [7:0] v;
      op(14'h304f, 8'h00, 8'h4f, 8'h18, 1'b0, 8'h00);
      op(14'h0062, 8'h00, 8'h4f, 8'h18, 1'b0, 8'h00);
      rd_chk(`MIE_OFF_OPTION, 32'h4f, "option");
      for (int i = 5; i <= 7; i++) begin
         v = 8'(i * 17);
         op({6'h30, v}, 8'h00, v, 8'h18, 1'b0, 8'h00);
         op(14'h0060 | 14'(i), 8'h00, v, 8'h18, 1'b0, 8'h00);
         rd_chk(12'(`MIE_OFF_DIR5 + 4 * (i - 5)), {24'h0, v}, "dir");
      end
      $display("test legacy done");
   endtask

   task automatic t_ret();
      wr(`MIE_OFF_STACK, 32'h123);
      wr(`MIE_OFF_STACK, 32'h456);
      run(14'h0008);
      rd_chk(`MIE_OFF_PC, 32'h456, "pc ret");
      chk({19'h0, stack_top}, 32'h123, "top");
      chk({31'h0, global_irq_enable}, 32'h0, "gie ret");
      op(14'h3466, 8'h00, 8'h66, 8'h18, 1'b0, 8'h00);
      rd_chk(`MIE_OFF_PC, 32'h123, "pc retlit");
      wr(`MIE_OFF_STACK, 32'h200);
      run(14'h0009);
      rd_chk(`MIE_OFF_PC, 32'h200, "pc retirq");
      chk({31'h0, global_irq_enable}, 32'h1, "gie");
      rd_chk(`MIE_OFF_INTERRUPT_CONTROL_REG, 32'h80, "interrupt_control_reg");
      $display("test return done");
   endtask

   task automatic t_idle();
      wr(`MIE_OFF_PC, 32'h100);
      op(14'h0000, 8'h55, 8'h66, 8'h18, 1'b0, 8'h00);
      rd_chk(`MIE_OFF_PC, 32'h101, "pc idle");
      op(14'h0060, 8'h55, 8'h66, 8'h18, 1'b0, 8'h00);
      rd_chk(`MIE_OFF_PC, 32'h102, "pc idle2");
      chk({19'h0, program_counter}, 32'h102, "pc pin");
      chk({31'h0, global_irq_enable}, 32'h1, "gie idle");
      $display("test idle done");
   endtask

   // Enable low must swallow a bus write
   task automatic t_freeze();
      @(posedge pclk);
      clk_en <= 1'b0;
      wr(`MIE_OFF_ACC, 32'h12);
      clk_en <= 1'b1;
      rd_chk(`MIE_OFF_ACC, 32'h66, "frozen acc");
      wr(`MIE_OFF_ACC, 32'h12);
      rd_chk(`MIE_OFF_ACC, 32'h12, "acc write");
      $display("test freeze done");
   endtask

   task automatic t_sleep();
      int n, d0;
      logic [31:0] q;
      d0 = wdcnt;
      wr(`MIE_OFF_INSTR, 32'h63);
      n = 0;
      while (osc_stop !== 1'b1 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, osc_stop}, 32'h1, "osc stop");
      // Clear pulse lands in the same cycle as entry
      repeat (2) @(posedge pclk);
      chk(32'(wdcnt - d0), 32'h1, "wdog clears");
      rd_chk(`MIE_OFF_STATUS, 32'h10, "status sleep");
      xfer(1'b0, `MIE_OFF_CTRL, 32'h0, q);
      chk({31'h0, q[1]}, 32'h1, "asleep");
      wr(`MIE_OFF_CTRL, 32'h0);
      n = 0;
      while (osc_stop !== 1'b0 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, osc_stop}, 32'h0, "wake");
      $display("test sleep done");
   endtask

   // ==========================================
   // Main sequence and verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      n_fail = 0;
      n_tests = 0;
      wcnt = 0;
      wdcnt = 0;
      cyc = 0;
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      file_rdata = 8'h00;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_logic();
      t_arith();
      t_rotate();
      t_legacy();
      t_ret();
      t_idle();
      t_freeze();
      t_sleep();
      conclude();
   end
endmodule

// >>> hdl/mie_exec.sv
// Executor for the second half of a 14-bit instruction set, APB slave.
// Assumes a single 250 MHz clock and software feeding one opcode at a time.
//
// Summary of operation
// - Destination bit 0 writes accumulator, 1 writes back the file register.
// - OR accumulator with file register, only zero flag updated.
// - Copy file register to destination, zero flag updated.
// - Store accumulator into file register, flags unchanged.
// - Return from interrupt pops stack, sets global enable, two cycles.
// - Legacy option load copies accumulator into option register.
// - Return with literal loads accumulator, pops stack, two cycles.
// - Plain return pops stack in two cycles, nothing else touched.
// - Rotate left through carry into selected destination.
// - Power-down clears powerdown flag, sets timeout, clears watchdog, stops.
// - Both subtracts compute by two's complement, update carry, nibble, zero.
// - Nibble exchange into selected destination, flags unchanged.
// - XOR literal with accumulator, zero flag updated.
// - XOR accumulator with file register, zero flag updated.
// - Legacy direction load for operands five to seven only.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mie_exec
   import mie_pkg::*;
#(
   parameter int STK = `MIE_STK_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [6:0] file_addr,
   input wire logic [7:0] file_rdata,
   output logic [7:0] file_wdata,
   output logic file_we,
   output logic [12:0] program_counter,
   output logic [12:0] stack_top,
   output logic watchdog_clear,
   output logic osc_stop,
   output logic global_irq_enable
);
   mie_core_t r_ff, nxt_r;
   logic [12:0] stack_mem [STK];
   logic [12:0] stack_wdata;
   logic stack_we;
   logic [2:0] sp_m1;
   mie_alu_out_t sub_out;
   logic [7:0] sub_min;
   logic acc_wr, bus_wr, bus_rd;
   logic [7:0] res;
   logic [3:0] op4;
   logic dbit;

   assign op4 = r_ff.instr[11:8];
   assign dbit = r_ff.instr[7];
   assign sp_m1 = r_ff.sp - 3'h1;
   assign bus_wr = psel && penable && pwrite;
   assign bus_rd = psel && !penable && !pwrite;
   assign sub_min = (r_ff.instr[13:12] == 2'b11) ? r_ff.instr[7:0]
                                                  : file_rdata;

   mie_sub #(.W(8)) u_sub (
      .minuend(sub_min),
      .subtrahend(r_ff.acc),
      .result(sub_out)
   );

   // ==========================================================
   // Stack memory, written only from the bus for test preload
   // ==========================================================
   assign stack_we = clk_en && bus_wr && (paddr == `MIE_OFF_STACK)
                     && r_ff.state == MIE_IDLE;
   assign stack_wdata = pwdata[12:0];
   always_ff @(posedge pclk) begin
      if (stack_we) begin
         stack_mem[r_ff.sp] <= stack_wdata;
      end
   end

   // ==========================================================
   // Execute and bus decode
   // ==========================================================
   always_comb begin
      nxt_r = r_ff;
      nxt_r.wdt_clr = 1'b0;
      file_addr = r_ff.instr[6:0];
      file_wdata = 8'h00;
      file_we = 1'b0;
      res = 8'h00;
      acc_wr = 1'b0;
      case (r_ff.state)
         MIE_IDLE: begin
         end
         MIE_EXEC: begin
            nxt_r.state = MIE_IDLE;
            nxt_r.pc = r_ff.pc + 13'h0001;
            if (r_ff.instr[13:12] == 2'b00) begin
               if (r_ff.instr[11:7] == 5'h01) begin
                  file_wdata = r_ff.acc;
                  file_we = 1'b1;
               end else if (r_ff.instr == `MIE_OP_RETFI) begin
                  nxt_r.interrupt_control_reg[`MIE_GIE_BIT] = 1'b1;
                  nxt_r.state = MIE_RET2;
               end else if (r_ff.instr == `MIE_OP_RET) begin
                  nxt_r.state = MIE_RET2;
               end else if (r_ff.instr == `MIE_OP_OPTLD) begin
                  nxt_r.option = r_ff.acc;
               end else if (r_ff.instr == `MIE_OP_PDOWN) begin
                  nxt_r.status[`MIE_ST_PD] = 1'b0;
                  nxt_r.status[`MIE_ST_TO] = 1'b1;
                  nxt_r.wdt_clr = 1'b1;
                  nxt_r.state = MIE_ASLEEP;
               end else if (r_ff.instr[13:3] == `MIE_OP_DIRHI &&
                            r_ff.instr[2:0] >= `MIE_DIR_LO) begin
                  case (r_ff.instr[2:0])
                     3'h5: nxt_r.dir5 = r_ff.acc;
                     3'h6: nxt_r.dir6 = r_ff.acc;
                     default: nxt_r.dir7 = r_ff.acc;
                  endcase
               end else if (op4 == `MIE_OP_IOR) begin
                  res = r_ff.acc | file_rdata;
                  acc_wr = 1'b1;
                  nxt_r.status[`MIE_ST_Z] = (res == 8'h00);
               end else if (op4 == `MIE_OP_XOR) begin
                  res = r_ff.acc ^ file_rdata;
                  acc_wr = 1'b1;
                  nxt_r.status[`MIE_ST_Z] = (res == 8'h00);
               end else if (op4 == `MIE_OP_COPY) begin
                  res = file_rdata;
                  acc_wr = 1'b1;
                  nxt_r.status[`MIE_ST_Z] = (res == 8'h00);
               end else if (op4 == `MIE_OP_SUBF) begin
                  res = sub_out.res;
                  acc_wr = 1'b1;
                  nxt_r.status[`MIE_ST_C] = sub_out.c;
                  nxt_r.status[`MIE_ST_DC] = sub_out.dc;
                  nxt_r.status[`MIE_ST_Z] = (res == 8'h00);
               end else if (op4 == `MIE_OP_RL) begin
                  res = {file_rdata[6:0], r_ff.status[`MIE_ST_C]};
                  acc_wr = 1'b1;
                  nxt_r.status[`MIE_ST_C] = file_rdata[7];
               end else if (op4 == `MIE_OP_RR) begin
                  res = {r_ff.status[`MIE_ST_C], file_rdata[7:1]};
                  acc_wr = 1'b1;
                  nxt_r.status[`MIE_ST_C] = file_rdata[0];
               end else if (op4 == `MIE_OP_SWAP) begin
                  res = {file_rdata[3:0], file_rdata[7:4]};
                  acc_wr = 1'b1;
               end
               // Idle op and unknown encodings fall through untouched
            end else if (r_ff.instr[13:12] == 2'b11) begin
               if (r_ff.instr[13:10] == `MIE_LIT_LOAD) begin
                  nxt_r.acc = r_ff.instr[7:0];
               end else if (r_ff.instr[13:10] == `MIE_LIT_RET) begin
                  nxt_r.acc = r_ff.instr[7:0];
                  nxt_r.state = MIE_RET2;
               end else if (r_ff.instr[11:9] == `MIE_LIT_SUB) begin
                  nxt_r.acc = sub_out.res;
                  nxt_r.status[`MIE_ST_C] = sub_out.c;
                  nxt_r.status[`MIE_ST_DC] = sub_out.dc;
                  nxt_r.status[`MIE_ST_Z] = (sub_out.res == 8'h00);
               end else if (op4 == `MIE_LIT_XOR) begin
                  nxt_r.acc = r_ff.acc ^ r_ff.instr[7:0];
                  nxt_r.status[`MIE_ST_Z] =
                     ((r_ff.acc ^ r_ff.instr[7:0]) == 8'h00);
               end
            end
            if (acc_wr) begin
               if (dbit) begin
                  file_wdata = res;
                  file_we = 1'b1;
               end else begin
                  nxt_r.acc = res;
               end
            end
         end
         MIE_RET2: begin
            // Second cycle of a return: pop into the counter
            nxt_r.pc = stack_mem[sp_m1];
            nxt_r.sp = sp_m1;
            nxt_r.state = MIE_IDLE;
         end
         MIE_ASLEEP: begin
            // Only a bus write clearing the control sleep bit wakes the core
         end
         default: nxt_r.state = MIE_IDLE;
      endcase

      // APB writes; an instruction is accepted only while idle
      if (bus_wr) begin
         if (paddr == `MIE_OFF_INSTR) begin
            if (r_ff.state == MIE_IDLE) begin
               nxt_r.instr = pwdata[13:0];
               nxt_r.state = MIE_EXEC;
            end
         end else if (paddr == `MIE_OFF_CTRL) begin
            if (r_ff.state == MIE_ASLEEP && !pwdata[`MIE_CTRL_SLEEP]) begin
               nxt_r.state = MIE_IDLE;
            end
         end else if (paddr == `MIE_OFF_ACC) begin
            nxt_r.acc = pwdata[7:0];
         end else if (paddr == `MIE_OFF_STATUS) begin
            nxt_r.status = pwdata[7:0];
         end else if (paddr == `MIE_OFF_PC) begin
            nxt_r.pc = pwdata[12:0];
         end else if (paddr == `MIE_OFF_STACK) begin
            if (r_ff.state == MIE_IDLE) begin
               nxt_r.sp = r_ff.sp + 3'h1;
            end
         end else if (paddr == `MIE_OFF_INTERRUPT_CONTROL_REG) begin
            nxt_r.interrupt_control_reg = pwdata[7:0];
         end
      end

      // Read data is latched in setup so it is stable in access
      if (bus_rd) begin
         nxt_r.prdata = 32'h0000_0000;
         if (paddr == `MIE_OFF_CTRL) begin
            nxt_r.prdata[`MIE_CTRL_BUSY] = (r_ff.state != MIE_IDLE);
            nxt_r.prdata[`MIE_CTRL_SLEEP] = (r_ff.state == MIE_ASLEEP);
         end else if (paddr == `MIE_OFF_INSTR) begin
            nxt_r.prdata[13:0] = r_ff.instr;
         end else if (paddr == `MIE_OFF_ACC) begin
            nxt_r.prdata[7:0] = r_ff.acc;
         end else if (paddr == `MIE_OFF_STATUS) begin
            nxt_r.prdata[7:0] = r_ff.status;
         end else if (paddr == `MIE_OFF_OPTION) begin
            nxt_r.prdata[7:0] = r_ff.option;
         end else if (paddr == `MIE_OFF_DIR5) begin
            nxt_r.prdata[7:0] = r_ff.dir5;
         end else if (paddr == `MIE_OFF_DIR6) begin
            nxt_r.prdata[7:0] = r_ff.dir6;
         end else if (paddr == `MIE_OFF_DIR7) begin
            nxt_r.prdata[7:0] = r_ff.dir7;
         end else if (paddr == `MIE_OFF_PC) begin
            nxt_r.prdata[12:0] = r_ff.pc;
         end else if (paddr == `MIE_OFF_STACK) begin
            nxt_r.prdata[12:0] = stack_mem[sp_m1];
         end else if (paddr == `MIE_OFF_INTERRUPT_CONTROL_REG) begin
            nxt_r.prdata[7:0] = r_ff.interrupt_control_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_ff.state <= MIE_IDLE;
         r_ff.instr <= 14'h0000;
         r_ff.acc <= `MIE_RST_BYTE;
         r_ff.status <= `MIE_RST_STATUS;
         r_ff.interrupt_control_reg <= `MIE_RST_BYTE;
         r_ff.option <= `MIE_RST_OPTION;
         r_ff.dir5 <= `MIE_RST_DIR;
         r_ff.dir6 <= `MIE_RST_DIR;
         r_ff.dir7 <= `MIE_RST_DIR;
         r_ff.pc <= `MIE_RST_PC;
         r_ff.sp <= 3'h0;
         r_ff.wdt_clr <= 1'b0;
         r_ff.prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         r_ff <= nxt_r;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign prdata = r_ff.prdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign program_counter = r_ff.pc;
   assign stack_top = stack_mem[sp_m1];
   assign watchdog_clear = r_ff.wdt_clr;
   assign osc_stop = (r_ff.state == MIE_ASLEEP);
   assign global_irq_enable = r_ff.interrupt_control_reg[`MIE_GIE_BIT];

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_ret_issue;
      r_ff.state == MIE_EXEC && (r_ff.instr == `MIE_OP_RET ||
         r_ff.instr == `MIE_OP_RETFI) && clk_en;
   endsequence

   AST_RET_TWO: assert property (@(posedge pclk) disable iff (!presetn)
      s_ret_issue |=> r_ff.state == MIE_RET2)
      else $error("return did not take a second cycle");
   AST_GIE_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr == `MIE_OP_RETFI && clk_en)
      |=> global_irq_enable)
      else $error("interrupt return left global enable clear");
   AST_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr == `MIE_OP_PDOWN && clk_en)
      |=> osc_stop && watchdog_clear && !r_ff.status[`MIE_ST_PD]
          && r_ff.status[`MIE_ST_TO])
      else $error("power-down sequence incomplete");
   AST_STORE_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr[13:7] == `MIE_OP_STORE
       && clk_en && !bus_wr)
      |=> $stable(r_ff.status))
      else $error("store changed a flag");
   AST_STORE_WR: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr[13:7] == `MIE_OP_STORE)
      |-> file_we && file_wdata == r_ff.acc)
      else $error("store did not write accumulator");
   AST_DEST_ACC: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr[13:12] == 2'b00
       && op4 == `MIE_OP_SWAP && !dbit && clk_en && !bus_wr)
      |=> r_ff.acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
      else $error("nibble exchange to accumulator wrong");
   AST_DEST_FILE: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr[13:12] == 2'b00
       && op4 == `MIE_OP_XOR && dbit)
      |-> file_we && file_wdata == (r_ff.acc ^ file_rdata))
      else $error("xor did not write back the file register");
   AST_LIT_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr[13:10] == 4'hc
       && clk_en && !bus_wr)
      |=> r_ff.acc == $past(r_ff.instr[7:0])
          && $stable(r_ff.status))
      else $error("literal load wrong");
   AST_RET_LIT: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr[13:10] == 4'hd
       && clk_en && !bus_wr)
      |=> r_ff.acc == $past(r_ff.instr[7:0])
          && r_ff.state == MIE_RET2)
      else $error("return with literal wrong");
   AST_IDLE_OP: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr == 14'h0000
       && clk_en && !bus_wr)
      |=> $stable(r_ff.acc) && $stable(r_ff.status)
          && r_ff.state == MIE_IDLE)
      else $error("idle op changed state");
   AST_SUB_C: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == MIE_EXEC && r_ff.instr[13:9] == 5'h1e
       && clk_en && !bus_wr)
      |=> r_ff.status[`MIE_ST_C] ==
          ($past(r_ff.instr[7:0]) >= $past(r_ff.acc)))
      else $error("subtract carry wrong");
endmodule

// >>> hdl/mie_pkg.sv
// Types for the second-half instruction executor.
// Assumes mie_regs.svh is on the include path.
package mie_pkg;
`include "mie_regs.svh"

   typedef enum logic [1:0] {
      MIE_IDLE   = 2'b00,
      MIE_EXEC   = 2'b01,
      MIE_RET2   = 2'b10,
      MIE_ASLEEP = 2'b11
   } mie_state_t;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       dc;
   } mie_alu_out_t;

   typedef struct packed {
      mie_state_t  state;
      logic [13:0] instr;
      logic [7:0]  acc;
      logic [7:0]  status;
      logic [7:0]  interrupt_control_reg;
      logic [7:0]  option;
      logic [7:0]  dir5;
      logic [7:0]  dir6;
      logic [7:0]  dir7;
      logic [12:0] pc;
      logic [2:0]  sp;
      logic        wdt_clr;
      logic [31:0] prdata;
   } mie_core_t;
endpackage

// >>> hdl/mie_regs.svh
// Constants for the second-half instruction executor: opcode fields,
// flag positions, reset values and register indices.
// Assumes inclusion by bare name from package and design files.
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH

// APB register byte offsets
`define MIE_OFF_CTRL    12'h000
`define MIE_OFF_INSTR   12'h004
`define MIE_OFF_ACC     12'h008
`define MIE_OFF_STATUS  12'h00c
`define MIE_OFF_FADDR   12'h010
`define MIE_OFF_FDATA   12'h014
`define MIE_OFF_OPTION  12'h018
`define MIE_OFF_DIR5    12'h01c
`define MIE_OFF_DIR6    12'h020
`define MIE_OFF_DIR7    12'h024
`define MIE_OFF_PC      12'h028
`define MIE_OFF_STACK   12'h02c
`define MIE_OFF_INTERRUPT_CONTROL_REG  12'h030

// Status and interrupt control flag positions
`define MIE_ST_C        0
`define MIE_ST_DC       1
`define MIE_ST_Z        2
`define MIE_ST_PD       3
`define MIE_ST_TO       4
`define MIE_GIE_BIT     7

// Control register bits
`define MIE_CTRL_BUSY   0
`define MIE_CTRL_SLEEP  1

// Reset values
`define MIE_RST_STATUS  8'h18
`define MIE_RST_OPTION  8'hff
`define MIE_RST_DIR     8'hff
`define MIE_RST_BYTE    8'h00
`define MIE_RST_PC      13'h0000

// Fixed opcodes and opcode masks
`define MIE_OP_RETFI    14'h0009
`define MIE_OP_RET      14'h0008
`define MIE_OP_OPTLD    14'h0062
`define MIE_OP_PDOWN    14'h0063
`define MIE_OP_DIRHI    11'h00c
`define MIE_OP_STORE    7'h01
`define MIE_OP_IOR      4'h4
`define MIE_OP_XOR      4'h6
`define MIE_OP_SUBF     4'h2
`define MIE_OP_COPY     4'h8
`define MIE_OP_RR       4'hc
`define MIE_OP_RL       4'hd
`define MIE_OP_SWAP     4'he
`define MIE_LIT_LOAD    4'hc
`define MIE_LIT_RET     4'hd
`define MIE_LIT_SUB     3'h6
`define MIE_LIT_XOR     4'ha
`define MIE_DIR_LO      3'h5
`define MIE_DIR_HI      3'h7
`define MIE_STK_DEPTH   8

`endif

// >>> hdl/mie_sub.sv
// Two's-complement subtractor: minuend minus accumulator.
// Assumes purely combinational use inside the executor.
`timescale 1ns/1ps
module mie_sub
   import mie_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic [W-1:0] minuend,
   input wire logic [W-1:0] subtrahend,
   output mie_alu_out_t result
);
   logic [W:0] full;
   logic [4:0] low;

   always_comb begin
      full = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
      low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
      result.res = full[W-1:0];
      // No borrow shows as carry set
      result.c = full[W];
      result.dc = low[4];
   end
endmodule
